// ==== dv/tb_top.sv ====
// Self-checking bench for the torque and current parameter bank.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tcpb_pkg::*;
    logic clk = 0, rstn = 0, vld = 0, wr = 0, slow = 0, rdy, rv, ra, nreq, nwr, nack, ev, imm, lin, idone;
    logic [15:0] idx = 0, ecode, maxc;
    logic [7:0] sub = 0;
    logic [31:0] wd = 0, nom = 32'h000030D4, peak = 32'h0000A028, lf = 32'h0000003A, d;
    logic [31:0] code, rdat, nwd, nrd, rated, slope;
    logic [1:0] naddr;
    logic [64:0] exp_q[$];
    logic [64:0] e;
    logic [15:0] emcy_q[$];
    logic [15:0] sh[3] = '{16'hFFFF, 16'h0001, 16'h0000};
    logic [31:0] sc[3] = '{ABT_NONE, ABT_NODATA, ABT_NONE};
    logic [1:0] si[3] = '{2'h2, 2'h2, 2'h1};
    int miscompares = 0, n_compared = 0;
    tcpb_bank dut (.sys_clk_i(clk), .rstn_i(rstn), .sdo_req_valid_i(vld), .sdo_req_ready_o(rdy),
        .sdo_req_write_i(wr), .sdo_req_index_i(idx), .sdo_req_subidx_i(sub), .sdo_req_wdata_i(wd),
        .sdo_rsp_valid_o(rv), .sdo_rsp_abort_o(ra), .sdo_rsp_code_o(code), .sdo_rsp_rdata_o(rdat),
        .motor_nominal_ma_i(nom), .motor_peak_ma_i(peak), .nvm_req_o(nreq), .nvm_write_o(nwr),
        .nvm_addr_o(naddr), .nvm_wdata_o(nwd), .nvm_rdata_i(nrd), .nvm_ack_i(nack), .emcy_valid_o(ev),
        .emcy_code_o(ecode), .rated_current_o(rated), .max_current_o(maxc), .torque_slope_o(slope),
        .ramp_immediate_o(imm), .ramp_linear_o(lin), .init_done_o(idone));
    tcpb_nvm_model u_nvm (.clk_i(clk), .slow_i(slow), .req_i(nreq), .write_i(nwr), .addr_i(naddr),
        .wdata_i(nwd), .rdata_o(nrd), .ack_o(nack));
    // Half-period toggle gives the 200 MHz clock.
    always #2.5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [64:0] exp, input logic [64:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Ready is only high in idle, so this also waits out the load and the store.
    task automatic wait_rdy;
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (rdy !== 1'b1) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic sdo(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] dv,
                       input logic [31:0] ec, input logic [31:0] er);
        exp_q.push_back({ec != 32'h0, ec, er});
        @(posedge clk);
        vld <= 1'b1;
        wr <= w;
        idx <= i;
        sub <= s;
        wd <= dv;
        @(posedge clk);
        wait_rdy();
        vld <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Every answer and emergency is matched against the oldest expectation.
    always @(posedge clk) begin
        if (rv === 1'b1) begin
            // An answer with no note is forced to mismatch.
            e = exp_q.size() > 0 ? exp_q.pop_front() : ~{ra, code, rdat};
            check("sdo answer", e, {ra, code, rdat});
        end
        if (ev === 1'b1) check("emcy code", emcy_q.size() > 0 ? emcy_q.pop_front() : ~ecode, ecode);
    end
    // Main sequence.
    initial begin
        emcy_q = '{EMCY_RATED, EMCY_MAX_CUR, EMCY_SLOPE, EMCY_SHAPE};
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        wait_rdy();
        sdo(0, IDX_RATED, SUB_VALUE, 0, ABT_NONE, RST_RATED);
        sdo(0, IDX_MAX_CUR, SUB_VALUE, 0, ABT_NONE, {16'h0000, RST_MAX_CUR});
        sdo(0, IDX_SLOPE, SUB_VALUE, 0, ABT_NONE, RST_SLOPE);
        sdo(0, IDX_SHAPE, SUB_VALUE, 0, ABT_NONE, 32'h0);
        sdo(1, IDX_RATED, SUB_VALUE, 32'h30D5, ABT_HIGH, 0);
        sdo(1, IDX_RATED, SUB_VALUE, 32'h0, ABT_RANGE, 0);
        sdo(1, IDX_SLOPE, SUB_VALUE, 32'h80000000, ABT_RANGE, 0);
        sdo(1, IDX_SLOPE, SUB_VALUE, 32'h0, ABT_RANGE, 0);
        sdo(1, IDX_MAX_CUR, SUB_VALUE, 32'h0, ABT_RANGE, 0);
        sdo(1, IDX_MAX_CUR, SUB_VALUE, 32'h8000, ABT_RANGE, 0);
        sdo(0, IDX_RATED, SUB_VALUE, 0, ABT_NONE, RST_RATED);
        sdo(1, IDX_RATED, SUB_VALUE, 32'h30D4, ABT_NONE, 0);
        sdo(1, IDX_MAX_CUR, SUB_VALUE, 32'h0CD1, ABT_HIGH, 0);
        sdo(1, IDX_MAX_CUR, SUB_VALUE, 32'h0CD0, ABT_NONE, 0);
        check("held currents", {32'h30D4, 16'h0CD0}, {rated, maxc});
        sdo(1, IDX_SLOPE, SUB_VALUE, WIDE_MAX, ABT_NONE, 0);
        for (int k = 0; k < 3; k++) begin
            sdo(1, IDX_SHAPE, SUB_VALUE, {16'h0, sh[k]}, sc[k], 0);
            check("ramp decode", si[k], {imm, lin});
        end
        for (int k = 0; k < 4; k++) begin
            lf = lfsr(lf);
            d = (lf & WIDE_MAX) | 32'h1;
            sdo(1, IDX_SLOPE, SUB_VALUE, d, ABT_NONE, 0);
            sdo(0, IDX_SLOPE, SUB_VALUE, 0, ABT_NONE, d);
        end
        sdo(1, 16'h6072, SUB_VALUE, 32'h5, ABT_NOOBJ, 0);
        sdo(1, IDX_MAX_CUR, 8'h01, 32'h5, ABT_NOSUB, 0);
        sdo(0, IDX_STORE, SUB_STORE_ALL, 0, ABT_STORE, 0);
        sdo(1, IDX_STORE, SUB_STORE_ALL, 32'h1, ABT_STORE, 0);
        slow <= 1'b1;
        sdo(1, IDX_STORE, SUB_STORE_ALL, SAVE_SIG, ABT_NONE, 0);
        wait_rdy();
        check("stored rated", 32'h30D4, u_nvm.mem[0]);
        check("stored max current", 32'h0CD0, u_nvm.mem[1]);
        check("stored slope", d, u_nvm.mem[2]);
        check("stored shape", 32'h0, u_nvm.mem[3]);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        check("init in reset", 1'b0, idone);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        wait_rdy();
        check("init done", 1'b1, idone);
        check("reloaded currents", {32'h30D4, 16'h0CD0}, {rated, maxc});
        check("reloaded slope and ramp", {d, 2'h1}, {slope, imm, lin});
        repeat (5) @(posedge clk);
        check("pending notes", 0, exp_q.size() + emcy_q.size());
        close_out();
    end
endmodule
`default_nettype wire

// ==== dv/tcpb_nvm_model.sv ====
// Behavioural non-volatile memory answering the bank's slot requests.
`default_nettype none
module tcpb_nvm_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic req_i,
    input wire logic write_i,
    input wire logic [1:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic ack_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem [4];
    logic [3:0] wait_cnt;
    // Start-up image: every slot invalid, so each load emergency is raised once.
    initial begin
        mem = '{32'h00000000, 32'h00008000, 32'h80000000, 32'h00000001};
        wait_cnt = 4'h0;
        ack_o = 1'b0;
        rdata_o = 32'h0;
    end
    // Data is valid only in the ack cycle; it toggles elsewhere so that a late sample is caught.
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o) begin
            if (wait_cnt >= (slow_i ? 4'h5 : 4'h0)) begin
                ack_o <= 1'b1;
                wait_cnt <= 4'h0;
                rdata_o <= mem[addr_i];
                if (write_i) mem[addr_i] <= wdata_i;
            end else wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/tcpb_bank.sv ====
// Torque and current parameter bank with checked writes, start-up load and store.
`default_nettype none
module tcpb_bank (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic sdo_req_valid_i,
    output logic sdo_req_ready_o,
    input wire logic sdo_req_write_i,
    input wire logic [15:0] sdo_req_index_i,
    input wire logic [7:0] sdo_req_subidx_i,
    input wire logic [31:0] sdo_req_wdata_i,
    output logic sdo_rsp_valid_o,
    output logic sdo_rsp_abort_o,
    output logic [31:0] sdo_rsp_code_o,
    output logic [31:0] sdo_rsp_rdata_o,
    input wire logic [31:0] motor_nominal_ma_i,
    input wire logic [31:0] motor_peak_ma_i,
    output logic nvm_req_o,
    output logic nvm_write_o,
    output logic [1:0] nvm_addr_o,
    output logic [31:0] nvm_wdata_o,
    input wire logic [31:0] nvm_rdata_i,
    input wire logic nvm_ack_i,
    output logic emcy_valid_o,
    output logic [15:0] emcy_code_o,
    output logic [31:0] rated_current_o,
    output logic [15:0] max_current_o,
    output logic [31:0] torque_slope_o,
    output logic ramp_immediate_o,
    output logic ramp_linear_o,
    output logic init_done_o
);
    import tcpb_pkg::*;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    tcpb_state_t state_reg, state_next;
    logic [1:0] slot_reg, slot_next;
    logic [31:0] rated_reg, rated_next;
    logic [15:0] max_cur_reg, max_cur_next;
    logic [31:0] slope_reg, slope_next;
    logic [15:0] shape_reg, shape_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [31:0] rsp_code_reg, rsp_code_next;
    logic [31:0] rsp_rdata_reg, rsp_rdata_next;
    logic emcy_valid_reg, emcy_valid_next;
    logic [15:0] emcy_code_reg, emcy_code_next;
    logic [31:0] nvm_wdata_reg, nvm_wdata_next;
    logic take;
    logic take_wr;
    logic [15:0] slot_index;
    tcpb_chk_if chk_bus ();

    // Reset release passes two flip-flops so every register leaves reset on the same edge.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Slot to object index, used by the load checks; store data is picked per slot directly.
    function automatic logic [15:0] slot_to_index(input logic [1:0] slot);
        case (slot)
            SLOT_RATED: slot_to_index = IDX_RATED;
            SLOT_MAX_CUR: slot_to_index = IDX_MAX_CUR;
            SLOT_SLOPE: slot_to_index = IDX_SLOPE;
            default: slot_to_index = IDX_SHAPE;
        endcase
    endfunction

    assign slot_index = slot_to_index(slot_reg);
    assign take = (state_reg == ST_IDLE) && sdo_req_valid_i;
    assign take_wr = take && sdo_req_write_i;

    // The checker sees the stored image during load and the master's value otherwise.
    // Rated current is loaded first so that the max current check already has its reference.
    assign chk_bus.index = (state_reg == ST_LOAD) ? slot_index : sdo_req_index_i;
    assign chk_bus.value = (state_reg == ST_LOAD) ? nvm_rdata_i : sdo_req_wdata_i;
    assign chk_bus.rated_ref = rated_reg;
    assign chk_bus.nominal_ma = motor_nominal_ma_i;
    assign chk_bus.peak_ma = motor_peak_ma_i;

    tcpb_check u_check (
        .chk(chk_bus)
    );

    // Sequencer: load the image, serve the master, and write the image back on request.
    always_comb begin
        state_next = state_reg;
        slot_next = slot_reg;
        rated_next = rated_reg;
        max_cur_next = max_cur_reg;
        slope_next = slope_reg;
        shape_next = shape_reg;
        rsp_valid_next = 1'b0;
        rsp_code_next = rsp_code_reg;
        rsp_rdata_next = rsp_rdata_reg;
        emcy_valid_next = 1'b0;
        emcy_code_next = emcy_code_reg;
        nvm_wdata_next = nvm_wdata_reg;
        case (state_reg)
            ST_LOAD: begin
                if (nvm_ack_i) begin
                    if (chk_bus.abort == ABT_NONE) begin
                        case (slot_reg)
                            SLOT_RATED: rated_next = nvm_rdata_i;
                            SLOT_MAX_CUR: max_cur_next = nvm_rdata_i[15:0];
                            SLOT_SLOPE: slope_next = nvm_rdata_i;
                            default: shape_next = nvm_rdata_i[15:0];
                        endcase
                    end else begin
                        // An invalid word keeps the reset default and is reported once.
                        emcy_valid_next = 1'b1;
                        case (slot_reg)
                            SLOT_RATED: emcy_code_next = EMCY_RATED;
                            SLOT_MAX_CUR: emcy_code_next = EMCY_MAX_CUR;
                            SLOT_SLOPE: emcy_code_next = EMCY_SLOPE;
                            default: emcy_code_next = EMCY_SHAPE;
                        endcase
                    end
                    slot_next = slot_reg + 2'h1;
                    if (slot_reg == SLOT_SHAPE) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_IDLE: begin
                if (take) begin
                    rsp_valid_next = 1'b1;
                    rsp_code_next = ABT_NONE;
                    rsp_rdata_next = 32'h00000000;
                    if (sdo_req_index_i == IDX_STORE) begin
                        if (sdo_req_write_i && sdo_req_subidx_i == SUB_STORE_ALL && sdo_req_wdata_i == SAVE_SIG) begin
                            // The answer waits until the last slot is written.
                            rsp_valid_next = 1'b0;
                            state_next = ST_STORE;
                            slot_next = SLOT_RATED;
                            nvm_wdata_next = rated_reg;
                        end else begin
                            rsp_code_next = ABT_STORE;
                        end
                    end else if (chk_bus.abort == ABT_NOOBJ) begin
                        rsp_code_next = ABT_NOOBJ;
                    end else if (sdo_req_subidx_i != SUB_VALUE) begin
                        rsp_code_next = ABT_NOSUB;
                    end else if (!sdo_req_write_i) begin
                        case (sdo_req_index_i)
                            IDX_RATED: rsp_rdata_next = rated_reg;
                            IDX_MAX_CUR: rsp_rdata_next = {16'h0000, max_cur_reg};
                            IDX_SLOPE: rsp_rdata_next = slope_reg;
                            default: rsp_rdata_next = {{16{shape_reg[15]}}, shape_reg};
                        endcase
                    end else if (chk_bus.abort != ABT_NONE) begin
                        rsp_code_next = chk_bus.abort;
                    end else begin
                        // Slope is taken at any time, motion running or not.
                        case (sdo_req_index_i)
                            IDX_RATED: rated_next = sdo_req_wdata_i;
                            IDX_MAX_CUR: max_cur_next = sdo_req_wdata_i[15:0];
                            IDX_SLOPE: slope_next = sdo_req_wdata_i;
                            default: shape_next = sdo_req_wdata_i[15:0];
                        endcase
                    end
                end
            end
            ST_STORE: begin
                if (nvm_ack_i) begin
                    slot_next = slot_reg + 2'h1;
                    case (slot_reg)
                        SLOT_RATED: nvm_wdata_next = {16'h0000, max_cur_reg};
                        SLOT_MAX_CUR: nvm_wdata_next = slope_reg;
                        default: nvm_wdata_next = {16'h0000, shape_reg};
                    endcase
                    if (slot_reg == SLOT_SHAPE) begin
                        state_next = ST_IDLE;
                        rsp_valid_next = 1'b1;
                        rsp_code_next = ABT_NONE;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Registers of the sequencer.
    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_LOAD;
            slot_reg <= SLOT_RATED;
            rated_reg <= RST_RATED;
            max_cur_reg <= RST_MAX_CUR;
            slope_reg <= RST_SLOPE;
            shape_reg <= RST_SHAPE;
            rsp_valid_reg <= 1'b0;
            rsp_code_reg <= ABT_NONE;
            rsp_rdata_reg <= 32'h00000000;
            emcy_valid_reg <= 1'b0;
            emcy_code_reg <= 16'h0000;
            nvm_wdata_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            slot_reg <= slot_next;
            rated_reg <= rated_next;
            max_cur_reg <= max_cur_next;
            slope_reg <= slope_next;
            shape_reg <= shape_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_code_reg <= rsp_code_next;
            rsp_rdata_reg <= rsp_rdata_next;
            emcy_valid_reg <= emcy_valid_next;
            emcy_code_reg <= emcy_code_next;
            nvm_wdata_reg <= nvm_wdata_next;
        end
    end

    // Port drive; the request strobes toward memory are handshakes and stay combinational.
    assign sdo_req_ready_o = (state_reg == ST_IDLE);
    assign sdo_rsp_valid_o = rsp_valid_reg;
    assign sdo_rsp_abort_o = rsp_valid_reg && (rsp_code_reg != ABT_NONE);
    assign sdo_rsp_code_o = rsp_code_reg;
    assign sdo_rsp_rdata_o = rsp_rdata_reg;
    assign nvm_req_o = (state_reg == ST_LOAD) || (state_reg == ST_STORE);
    assign nvm_write_o = (state_reg == ST_STORE);
    assign nvm_addr_o = slot_reg;
    assign nvm_wdata_o = nvm_wdata_reg;
    assign emcy_valid_o = emcy_valid_reg;
    assign emcy_code_o = emcy_code_reg;
    assign rated_current_o = rated_reg;
    assign max_current_o = max_cur_reg;
    assign torque_slope_o = slope_reg;
    assign ramp_immediate_o = (shape_reg == SHAPE_IMMEDIATE);
    assign ramp_linear_o = (shape_reg == SHAPE_LINEAR);
    assign init_done_o = (state_reg != ST_LOAD);

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_param_write(logic [15:0] idx);
        take_wr && sdo_req_index_i == idx && sdo_req_subidx_i == SUB_VALUE;
    endsequence

    sequence s_save_taken;
        take_wr && sdo_req_index_i == IDX_STORE && sdo_req_subidx_i == SUB_STORE_ALL && sdo_req_wdata_i == SAVE_SIG;
    endsequence

    sequence s_load_bad(logic [1:0] slot);
        state_reg == ST_LOAD && slot_reg == slot && nvm_ack_i && chk_bus.abort != ABT_NONE;
    endsequence

    AST_REFUSED_KEEPS: assert property (take_wr && chk_bus.abort != ABT_NONE |=>
        $stable(rated_current_o) && $stable(max_current_o) && $stable(torque_slope_o) && $stable(shape_reg))
        else $error("Refused write changed a held value.");

    AST_SLOPE_RANGE: assert property (s_param_write(IDX_SLOPE) ##0 sdo_req_wdata_i == 32'h00000000 |=>
        sdo_rsp_valid_o && sdo_rsp_abort_o && sdo_rsp_code_o == ABT_RANGE)
        else $error("Zero slope was not refused as out of range.");

    AST_MAX_CUR_RANGE: assert property (s_param_write(IDX_MAX_CUR) ##0 sdo_req_wdata_i == 32'h00008000 |=>
        sdo_rsp_code_o == ABT_RANGE)
        else $error("Max current 32768 was not refused as out of range.");

    AST_RATED_HIGH: assert property (s_param_write(IDX_RATED) ##0 (sdo_req_wdata_i <= WIDE_MAX)
        ##0 (sdo_req_wdata_i > motor_nominal_ma_i) ##0 (sdo_req_wdata_i != 32'h00000000) |=>
        sdo_rsp_code_o == ABT_HIGH && rated_current_o == $past(rated_current_o))
        else $error("Rated current above nominal was not refused as too high.");

    AST_MAX_CUR_HIGH: assert property (s_param_write(IDX_MAX_CUR)
        ##0 (sdo_req_wdata_i >= MAX_CUR_MIN && sdo_req_wdata_i <= MAX_CUR_MAX)
        ##0 (48'(rated_current_o) * 48'(sdo_req_wdata_i[15:0]) > 48'(motor_peak_ma_i) * PERMILLE) |=>
        sdo_rsp_code_o == ABT_HIGH)
        else $error("Max current above peak was not refused as too high.");

    AST_SLOPE_TAKEN: assert property (s_param_write(IDX_SLOPE) ##0 chk_bus.abort == ABT_NONE |=>
        torque_slope_o == $past(sdo_req_wdata_i) && sdo_rsp_valid_o && !sdo_rsp_abort_o)
        else $error("A valid slope was not adopted.");

    AST_SHAPE_IMMEDIATE: assert property (s_param_write(IDX_SHAPE) ##0 sdo_req_wdata_i[15:0] == SHAPE_IMMEDIATE
        |=> ramp_immediate_o && !ramp_linear_o)
        else $error("Immediate shape was not decoded.");

    AST_SHAPE_SINSQ: assert property (s_param_write(IDX_SHAPE) ##0 sdo_req_wdata_i[15:0] == SHAPE_SINSQ |=>
        sdo_rsp_code_o == ABT_NODATA && $stable(ramp_immediate_o) && $stable(ramp_linear_o))
        else $error("Sine-squared shape was adopted or not refused.");

    AST_EMCY_RATED: assert property (s_load_bad(SLOT_RATED) |=> emcy_valid_o && emcy_code_o == EMCY_RATED
        ##1 !emcy_valid_o)
        else $error("Invalid stored rated current gave no single emergency.");

    AST_EMCY_MAX_CUR: assert property (s_load_bad(SLOT_MAX_CUR) |=> emcy_valid_o && emcy_code_o == EMCY_MAX_CUR)
        else $error("Invalid stored max current gave no emergency.");

    AST_EMCY_SHAPE: assert property (s_load_bad(SLOT_SHAPE) |=> emcy_valid_o && emcy_code_o == EMCY_SHAPE
        && init_done_o)
        else $error("Invalid stored shape gave no emergency.");

    AST_STORE_START: assert property (s_save_taken |=> nvm_req_o && nvm_write_o && nvm_addr_o == SLOT_RATED
        && nvm_wdata_o == rated_current_o && !sdo_rsp_valid_o)
        else $error("Save did not start writing the rated current.");

    AST_STORE_END: assert property (state_reg == ST_STORE && slot_reg == SLOT_SHAPE && nvm_ack_i |=>
        sdo_rsp_valid_o && !sdo_rsp_abort_o && sdo_req_ready_o)
        else $error("Store did not finish with a success answer.");
endmodule
`default_nettype wire

// ==== rtl/tcpb_check.sv ====
// Value checker: gives the abort code a candidate value earns.
`default_nettype none
module tcpb_check (
    tcpb_chk_if.chk chk
);
    import tcpb_pkg::*;

    logic [47:0] cur_x1000;
    logic [47:0] peak_x1000;

    // Max current in mArms times 1000 is compared with peak times 1000, so no division is needed.
    assign cur_x1000 = 48'(chk.rated_ref) * 48'(chk.value[15:0]);
    assign peak_x1000 = 48'(chk.peak_ma) * PERMILLE;

    // Range first, then the motor limit; an unknown index is no object.
    always_comb begin
        chk.abort = ABT_NONE;
        case (chk.index)
            IDX_RATED: begin
                if (chk.value < WIDE_MIN || chk.value > WIDE_MAX) begin
                    chk.abort = ABT_RANGE;
                end else if (chk.value > chk.nominal_ma) begin
                    chk.abort = ABT_HIGH;
                end
            end
            IDX_MAX_CUR: begin
                if (chk.value < MAX_CUR_MIN || chk.value > MAX_CUR_MAX) begin
                    chk.abort = ABT_RANGE;
                end else if (cur_x1000 > peak_x1000) begin
                    chk.abort = ABT_HIGH;
                end
            end
            IDX_SLOPE: begin
                if (chk.value < WIDE_MIN || chk.value > WIDE_MAX) begin
                    chk.abort = ABT_RANGE;
                end
            end
            IDX_SHAPE: begin
                // The sine-squared ramp and every other code are not available.
                if (chk.value[15:0] != SHAPE_IMMEDIATE && chk.value[15:0] != SHAPE_LINEAR) begin
                    chk.abort = ABT_NODATA;
                end
            end
            default: chk.abort = ABT_NOOBJ;
        endcase
    end
endmodule
`default_nettype wire

// ==== rtl/tcpb_chk_if.sv ====
// Carrier between the bank and its value checker.
`default_nettype none
interface tcpb_chk_if;
    logic [15:0] index;
    logic [31:0] value;
    logic [31:0] rated_ref;
    logic [31:0] nominal_ma;
    logic [31:0] peak_ma;
    logic [31:0] abort;
    modport req (output index, output value, output rated_ref, output nominal_ma, output peak_ma, input abort);
    modport chk (input index, input value, input rated_ref, input nominal_ma, input peak_ma, output abort);
endinterface
`default_nettype wire

// ==== rtl/tcpb_pkg.sv ====
// Constants and types shared by the torque and current parameter bank.
`default_nettype none
package tcpb_pkg;
    // Object indices and sub-indices of the bank and of the store object.
    localparam logic [15:0] IDX_MAX_CUR = 16'h6073;
    localparam logic [15:0] IDX_RATED = 16'h6075;
    localparam logic [15:0] IDX_SLOPE = 16'h6087;
    localparam logic [15:0] IDX_SHAPE = 16'h6088;
    localparam logic [15:0] IDX_STORE = 16'h1010;
    localparam logic [7:0] SUB_VALUE = 8'h00;
    localparam logic [7:0] SUB_STORE_ALL = 8'h01;
    localparam logic [31:0] SAVE_SIG = 32'h65766173;

    // Abort codes returned on the answer port; zero means success.
    localparam logic [31:0] ABT_NONE = 32'h00000000;
    localparam logic [31:0] ABT_RANGE = 32'h06040030;
    localparam logic [31:0] ABT_HIGH = 32'h06090031;
    localparam logic [31:0] ABT_NODATA = 32'h08000024;
    localparam logic [31:0] ABT_NOOBJ = 32'h06020000;
    localparam logic [31:0] ABT_NOSUB = 32'h06090011;
    localparam logic [31:0] ABT_STORE = 32'h08000020;

    // Emergency codes raised by the start-up load.
    localparam logic [15:0] EMCY_RATED = 16'h8B1F;
    localparam logic [15:0] EMCY_MAX_CUR = 16'h8B22;
    localparam logic [15:0] EMCY_SLOPE = 16'h8B25;
    localparam logic [15:0] EMCY_SHAPE = 16'h8B18;

    // Value ranges and the per-thousand scale.
    localparam logic [31:0] WIDE_MIN = 32'h00000001;
    localparam logic [31:0] WIDE_MAX = 32'h7FFFFFFF;
    localparam logic [31:0] MAX_CUR_MIN = 32'h00000001;
    localparam logic [31:0] MAX_CUR_MAX = 32'h00007FFF;
    localparam logic [47:0] PERMILLE = 48'h0000000003E8;

    // Ramp shape encodings.
    localparam logic [15:0] SHAPE_IMMEDIATE = 16'hFFFF;
    localparam logic [15:0] SHAPE_LINEAR = 16'h0000;
    localparam logic [15:0] SHAPE_SINSQ = 16'h0001;

    // Values held until the stored image is loaded, or kept when it is invalid.
    localparam logic [31:0] RST_RATED = 32'h000003E8;
    localparam logic [15:0] RST_MAX_CUR = 16'h03E8;
    localparam logic [31:0] RST_SLOPE = 32'h000003E8;
    localparam logic [15:0] RST_SHAPE = 16'h0000;

    // Non-volatile slots, loaded and stored in this order.
    localparam logic [1:0] SLOT_RATED = 2'h0;
    localparam logic [1:0] SLOT_MAX_CUR = 2'h1;
    localparam logic [1:0] SLOT_SLOPE = 2'h2;
    localparam logic [1:0] SLOT_SHAPE = 2'h3;

    typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_STORE} tcpb_state_t;
endpackage
`default_nettype wire
